// >>> hw/ccp_pkg.sv
package ccp_pkg;

  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned REG_COUNT  = 128;
  localparam int unsigned FRAME_BITS = 16;

  // Bit counter for one byte of a frame.
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;

  // Register map.
  localparam logic [ADDR_W-1:0] ADDR_RATE_CONV_CLOCK_CONTROL = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_RECEIVER_ERROR_DETAIL   = 7'h18;
  localparam logic [ADDR_W-1:0] ADDR_RATE_CONV_ERROR_DETAIL  = 7'h1a;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_STATUS        = 7'h1c;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_MASK          = 7'h1d;
  localparam logic [ADDR_W-1:0] ADDR_PIN_CONTROL             = 7'h1e;

  // Interrupt status layout.
  localparam int unsigned STAT_RATE_CONV_FAULT = 7;
  localparam int unsigned STAT_RECEIVER_FAULT  = 6;
  localparam int unsigned STAT_EVENT_W         = 6;

  // Pin control layout.
  localparam int unsigned PIN_IRQ_SELECT_BIT = 0;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 7'h01;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ  = 4'b1000
  } ccp_state_e;

endpackage

// >>> hw/ccp_ctrl_port.sv
`timescale 1ns/10ps

// Functional notes
// - A frame is eight bits plus eight per byte, one per clock.
// - Latch falling starts a new frame.
// - Seven address bits, then direction bit.
// - Direction low: next byte written to register.
// - Direction high: register shifted out next byte.
// - Input bits ignored during a read.
// - Block write increments address per byte.
// - Block read increments address per byte.
// - Every register is eight bits wide.
// - Status bits sticky until status register read.
// - Mask bit gates each status bit.
// - Two fault flags, detail in error registers.
// - Select bit picks zero-left or interrupt.
module ccp_ctrl_port
  import ccp_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire logic                    ctrl_latch_n,
  input  wire logic                    ctrl_serial_clock,
  input  wire logic                    ctrl_serial_in,
  output logic                         ctrl_serial_out,
  output logic                         ctrl_serial_out_oe,
  input  wire logic [STAT_EVENT_W-1:0] irq_event,
  input  wire logic [DATA_W-1:0]       receiver_error_event,
  input  wire logic [DATA_W-1:0]       rate_conv_error_event,
  input  wire logic                    zero_left_flag,
  output logic                         zero_left_or_irq_pin,
  output logic                         irq_pending
);

  logic [2:0]             clk_sync_reg;
  logic [2:0]             latch_sync_reg;
  logic [2:0]             din_sync_reg;
  logic                   clk_lvl_reg;
  logic                   latch_lvl_reg;
  logic                   din_lvl_reg;
  logic                   clk_rise;
  logic                   clk_fall;
  logic                   latch_fall;
  logic                   latch_rise;
  ccp_state_e             state_reg;
  logic [2:0]             in_cnt_reg;
  logic [2:0]             out_cnt_reg;
  logic [ADDR_W-1:0]      in_shift_reg;
  logic [ADDR_W-1:0]      addr_reg;
  logic [DATA_W-1:0]      tx_shift_reg;
  logic [DATA_W-1:0]      mem [REG_COUNT];
  logic [DATA_W-1:0]      status_reg;
  logic [DATA_W-1:0]      rx_detail_reg;
  logic [DATA_W-1:0]      src_detail_reg;
  logic                   first_load;
  logic                   next_load;
  logic                   rd_fire;
  logic [ADDR_W-1:0]      rd_addr;
  logic                   wr_fire;
  logic [DATA_W-1:0]      wr_data;
  logic                   pin_reg;
  logic [DATA_W-1:0]      status_set;

  // Read view of the map; returns 8 bits for any address.
  function automatic logic [DATA_W-1:0] reg_view(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = mem[a];
    if (a == ADDR_RECEIVER_ERROR_DETAIL) begin
      v = rx_detail_reg;
    end else if (a == ADDR_RATE_CONV_ERROR_DETAIL) begin
      v = src_detail_reg;
    end else if (a == ADDR_INTERRUPT_STATUS) begin
      v = status_reg;
    end
    return v;
  endfunction

  // Filtered edge detector: a change counts once stages two and three agree.
  function automatic logic settled_change(input logic [2:0] s, input logic lvl);
    return (s[1] == s[2]) && (s[2] != lvl);
  endfunction

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_sync_reg   <= 3'h0;
      latch_sync_reg <= 3'h7;
      din_sync_reg   <= 3'h0;
    end else begin
      clk_sync_reg   <= {clk_sync_reg[1:0], ctrl_serial_clock};
      latch_sync_reg <= {latch_sync_reg[1:0], ctrl_latch_n};
      din_sync_reg   <= {din_sync_reg[1:0], ctrl_serial_in};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_lvl_reg   <= 1'b0;
      latch_lvl_reg <= 1'b1;
      din_lvl_reg   <= 1'b0;
    end else begin
      if (settled_change(clk_sync_reg, clk_lvl_reg)) begin
        clk_lvl_reg <= clk_sync_reg[2];
      end
      if (settled_change(latch_sync_reg, latch_lvl_reg)) begin
        latch_lvl_reg <= latch_sync_reg[2];
      end
      if (settled_change(din_sync_reg, din_lvl_reg)) begin
        din_lvl_reg <= din_sync_reg[2];
      end
    end
  end

  assign clk_rise   = settled_change(clk_sync_reg, clk_lvl_reg) && clk_sync_reg[2];
  assign clk_fall   = settled_change(clk_sync_reg, clk_lvl_reg) && !clk_sync_reg[2];
  assign latch_fall = settled_change(latch_sync_reg, latch_lvl_reg) && !latch_sync_reg[2];
  assign latch_rise = settled_change(latch_sync_reg, latch_lvl_reg) && latch_sync_reg[2];

  // Byte loads for the output shifter; each load counts as a read of that register.
  assign first_load = (state_reg == ST_ADDR) && clk_rise && (in_cnt_reg == BIT_LAST) && din_lvl_reg;
  assign next_load  = (state_reg == ST_READ) && clk_fall && (out_cnt_reg == BIT_LAST);
  assign rd_fire    = first_load || next_load;
  assign rd_addr    = first_load ? in_shift_reg : addr_reg + ADDR_ONE;
  assign wr_fire    = (state_reg == ST_WRITE) && clk_rise && (in_cnt_reg == BIT_LAST);
  assign wr_data    = {in_shift_reg, din_lvl_reg};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else if (latch_rise) begin
      state_reg <= ST_IDLE;
    end else if (latch_fall) begin
      state_reg <= ST_ADDR;
    end else if (state_reg == ST_ADDR && clk_rise && in_cnt_reg == BIT_LAST) begin
      state_reg <= din_lvl_reg ? ST_READ : ST_WRITE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      in_cnt_reg   <= BIT_ZERO;
      in_shift_reg <= '0;
    end else if (latch_fall) begin
      in_cnt_reg   <= BIT_ZERO;
      in_shift_reg <= '0;
    end else if (clk_rise && (state_reg == ST_ADDR || state_reg == ST_WRITE)) begin
      in_cnt_reg   <= in_cnt_reg + 3'h1;
      in_shift_reg <= {in_shift_reg[ADDR_W-2:0], din_lvl_reg};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= '0;
    end else if (state_reg == ST_ADDR && clk_rise && in_cnt_reg == BIT_LAST) begin
      addr_reg <= in_shift_reg;
    end else if (wr_fire || next_load) begin
      addr_reg <= addr_reg + ADDR_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem[i] <= REG_RESET;
      end
    end else if (wr_fire && addr_reg != ADDR_RECEIVER_ERROR_DETAIL && addr_reg != ADDR_RATE_CONV_ERROR_DETAIL &&
                 addr_reg != ADDR_INTERRUPT_STATUS) begin
      mem[addr_reg] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_shift_reg       <= REG_RESET;
      out_cnt_reg        <= BIT_ZERO;
      ctrl_serial_out    <= 1'b0;
      ctrl_serial_out_oe <= 1'b0;
    end else if (state_reg != ST_READ && !first_load) begin
      out_cnt_reg        <= BIT_ZERO;
      ctrl_serial_out    <= 1'b0;
      ctrl_serial_out_oe <= 1'b0;
    end else if (first_load) begin
      tx_shift_reg <= reg_view(rd_addr);
      out_cnt_reg  <= BIT_ZERO;
    end else if (clk_fall) begin
      ctrl_serial_out    <= tx_shift_reg[DATA_W-1];
      ctrl_serial_out_oe <= 1'b1;
      out_cnt_reg        <= out_cnt_reg + 3'h1;
      if (next_load) begin
        tx_shift_reg <= reg_view(rd_addr);
      end else begin
        tx_shift_reg <= {tx_shift_reg[DATA_W-2:0], 1'b0};
      end
    end
  end

  always_comb begin
    status_set                       = '0;
    status_set[STAT_EVENT_W-1:0]     = irq_event;
    status_set[STAT_RECEIVER_FAULT]  = |receiver_error_event;
    status_set[STAT_RATE_CONV_FAULT] = |rate_conv_error_event;
  end

  // sticky, cleared by read; a new event wins
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status_reg <= REG_RESET;
    end else if (rd_fire && rd_addr == ADDR_INTERRUPT_STATUS) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_detail_reg  <= REG_RESET;
      src_detail_reg <= REG_RESET;
    end else begin
      if (rd_fire && rd_addr == ADDR_RECEIVER_ERROR_DETAIL) begin
        rx_detail_reg <= receiver_error_event;
      end else begin
        rx_detail_reg <= rx_detail_reg | receiver_error_event;
      end
      if (rd_fire && rd_addr == ADDR_RATE_CONV_ERROR_DETAIL) begin
        src_detail_reg <= rate_conv_error_event;
      end else begin
        src_detail_reg <= src_detail_reg | rate_conv_error_event;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_pending <= 1'b0;
      pin_reg     <= 1'b0;
    end else begin
      irq_pending <= |(status_reg & mem[ADDR_INTERRUPT_MASK]);
      pin_reg     <= mem[ADDR_PIN_CONTROL][PIN_IRQ_SELECT_BIT] ? |(status_reg & mem[ADDR_INTERRUPT_MASK])
                                                                : zero_left_flag;
    end
  end

  assign zero_left_or_irq_pin = pin_reg;

endmodule

// >>> sim/ccp_host.sv
`timescale 1ns/10ps
module ccp_host (
  input  wire logic clk_sys,
  output logic      ctrl_latch_n,
  output logic      ctrl_serial_clock,
  output logic      ctrl_serial_in,
  input  wire logic ctrl_serial_out
);
  initial begin
    ctrl_latch_n = 1'b1;
    ctrl_serial_clock = 1'b0;
    ctrl_serial_in = 1'b0;
  end
  task automatic xfer(input logic [6:0] a, input logic rw, input int n, input logic [31:0] wd,
                      output logic [31:0] rd);
    logic [39:0] sh;
    sh = {a, rw, wd};
    rd = '0;
    @(posedge clk_sys);
    ctrl_latch_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int c = 1; c <= 8 + 8 * n; c++) begin
      ctrl_serial_in <= (rw && c > 8) ? c[0] : sh[39];
      sh = sh << 1;
      repeat (4) @(posedge clk_sys);
      ctrl_serial_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      if (c > 8) rd = {rd[30:0], ctrl_serial_out};
      ctrl_serial_clock <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    ctrl_latch_n <= 1'b1;
    ctrl_serial_in <= ~ctrl_serial_in;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// >>> sim/ccp_ctrl_port_sva.sv
`timescale 1ns/10ps
module ccp_ctrl_port_chk
  import ccp_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    nrst,
  input wire logic                    ctrl_latch_n,
  input wire logic                    ctrl_serial_clock,
  input wire logic                    ctrl_serial_in,
  input wire logic                    ctrl_serial_out,
  input wire logic                    ctrl_serial_out_oe,
  input wire logic [STAT_EVENT_W-1:0] irq_event,
  input wire logic [DATA_W-1:0]       receiver_error_event,
  input wire logic [DATA_W-1:0]       rate_conv_error_event,
  input wire logic                    zero_left_flag,
  input wire logic                    zero_left_or_irq_pin,
  input wire logic                    irq_pending
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |-> !irq_pending && !ctrl_serial_out_oe)
    else $error("outputs active in reset");
  a_oe_idle: assert property (ctrl_latch_n [*8] |-> !ctrl_serial_out_oe)
    else $error("read enable outside frame");
  a_oe_start: assert property ($rose(ctrl_serial_out_oe) |-> !ctrl_latch_n && $past(!ctrl_latch_n, 8))
    else $error("read enable without frame");
  a_out_hold: assert property (ctrl_serial_clock && $past(ctrl_serial_clock) && $past(ctrl_serial_out_oe) |->
      $stable(ctrl_serial_out))
    else $error("serial out moved while clock high");
  a_out_on_fall: assert property ($changed(ctrl_serial_out) && ctrl_serial_out_oe |->
      !$past(ctrl_serial_clock, 4) && $past(ctrl_serial_clock, 5))
    else $error("serial out moved away from falling edge");
  a_irq_sticky: assert property (irq_pending && ctrl_latch_n && $past(ctrl_latch_n, 8) |=> irq_pending)
    else $error("pending dropped without a read");
  a_irq_cause: assert property ($rose(irq_pending) |->
      !ctrl_latch_n || $past(|{irq_event, receiver_error_event, rate_conv_error_event}, 2))
    else $error("pending rose without event");
  a_pin_source: assert property (zero_left_or_irq_pin == $past(zero_left_flag) || zero_left_or_irq_pin == irq_pending)
    else $error("dual pin follows neither source");
endmodule
bind ccp_ctrl_port ccp_ctrl_port_chk chk (.clk_sys, .nrst, .ctrl_latch_n, .ctrl_serial_clock, .ctrl_serial_in,
  .ctrl_serial_out, .ctrl_serial_out_oe, .irq_event, .receiver_error_event, .rate_conv_error_event,
  .zero_left_flag, .zero_left_or_irq_pin, .irq_pending);

// >>> sim/test_codec_control_port_irq.sv
`timescale 1ns/10ps
module test_codec_control_port_irq
  import ccp_pkg::*;
;
  logic                    clk_sys = 1'b0;
  logic                    nrst = 1'b0;
  logic [STAT_EVENT_W-1:0] irq_event = '0;
  logic [DATA_W-1:0]       receiver_error_event = '0;
  logic [DATA_W-1:0]       rate_conv_error_event = '0;
  logic                    zero_left_flag = 1'b0;
  logic                    ctrl_latch_n, ctrl_serial_clock, ctrl_serial_in, ctrl_serial_out;
  logic                    ctrl_serial_out_oe, zero_left_or_irq_pin, irq_pending;
  logic [31:0]             rd;
  int                      n_fail = 0;
  int                      cmp_count = 0;
  always #20 clk_sys = ~clk_sys;
  ccp_ctrl_port uut (.clk_sys, .nrst, .ctrl_latch_n, .ctrl_serial_clock, .ctrl_serial_in, .ctrl_serial_out,
    .ctrl_serial_out_oe, .irq_event, .receiver_error_event, .rate_conv_error_event, .zero_left_flag,
    .zero_left_or_irq_pin, .irq_pending);
  ccp_host host (.clk_sys, .ctrl_latch_n, .ctrl_serial_clock, .ctrl_serial_in, .ctrl_serial_out);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input int n, input logic [31:0] exp);
    logic [31:0] r;
    host.xfer(a, 1'b1, n, '0, r);
    chk(r, exp);
  endtask
  task automatic pulse(input logic [5:0] ev, input logic [7:0] rx, input logic [7:0] rc);
    irq_event <= ev;
    receiver_error_event <= rx;
    rate_conv_error_event <= rc;
    @(posedge clk_sys);
    irq_event <= '0;
    receiver_error_event <= '0;
    rate_conv_error_event <= '0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_block();
    chk({irq_pending, zero_left_or_irq_pin, ctrl_serial_out_oe}, '0);
    rdc(ADDR_RATE_CONV_CLOCK_CONTROL, 1, REG_RESET);
    host.xfer(ADDR_RATE_CONV_CLOCK_CONTROL, 1'b0, 3, 32'hA53C_7E00, rd);
    rdc(ADDR_RATE_CONV_CLOCK_CONTROL, 3, 32'h00A5_3C7E);
    rdc(ADDR_ONE, 1, 32'h0000_003C);
  endtask
  task automatic t_irq();
    host.xfer(ADDR_INTERRUPT_MASK, 1'b0, 2, 32'h0101_0000, rd);
    pulse(6'h03, '0, '0);
    chk({irq_pending, zero_left_or_irq_pin}, 32'h0000_0003);
    rdc(ADDR_INTERRUPT_STATUS, 1, 32'h0000_0003);
    chk({irq_pending, zero_left_or_irq_pin}, '0);
    rdc(ADDR_INTERRUPT_STATUS, 1, '0);
    pulse(6'h02, '0, '0);
    chk(irq_pending, '0);
    rdc(ADDR_INTERRUPT_STATUS, 1, 32'h0000_0002);
    host.xfer(ADDR_PIN_CONTROL, 1'b0, 1, '0, rd);
    pulse(6'h01, '0, '0);
    chk({irq_pending, zero_left_or_irq_pin}, 32'h0000_0002);
    zero_left_flag <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({irq_pending, zero_left_or_irq_pin}, 32'h0000_0003);
    zero_left_flag <= 1'b0;
    rdc(ADDR_INTERRUPT_STATUS, 1, 32'h0000_0001);
  endtask
  task automatic t_fault();
    pulse('0, 8'h24, 8'h81);
    rdc(ADDR_RECEIVER_ERROR_DETAIL, 1, 32'h0000_0024);
    rdc(ADDR_RATE_CONV_ERROR_DETAIL, 1, 32'h0000_0081);
    rdc(ADDR_INTERRUPT_STATUS, 1, 32'h0000_00C0);
    host.xfer(ADDR_RECEIVER_ERROR_DETAIL, 1'b0, 1, 32'hFF00_0000, rd);
    rdc(ADDR_RECEIVER_ERROR_DETAIL, 1, '0);
  endtask
  task automatic t_reset();
    host.xfer(ADDR_RATE_CONV_CLOCK_CONTROL, 1'b0, 1, 32'h5A00_0000, rd);
    pulse(6'h01, 8'h01, '0);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({irq_pending, zero_left_or_irq_pin, ctrl_serial_out_oe}, '0);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdc(ADDR_RATE_CONV_CLOCK_CONTROL, 1, REG_RESET);
    rdc(ADDR_INTERRUPT_STATUS, 1, '0);
    rdc(ADDR_RECEIVER_ERROR_DETAIL, 1, '0);
  endtask
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_block();
    t_irq();
    t_fault();
    t_reset();
    test_done();
  end
endmodule
